// File: logic/sgmc_pkg.sv
// shared constants for the serial gain and mode configuration port
package sgmc_pkg;
    localparam int          SGMC_WORD_BITS  = 5;
    localparam int          SGMC_GAIN_HI    = 4;
    localparam int          SGMC_GAIN_LO    = 3;
    localparam int          SGMC_AMP_EN     = 2;
    localparam int          SGMC_NULL       = 1;
    localparam int          SGMC_TRISTATE   = 0;
    localparam logic [4:0]  SGMC_CFG_RESET  = 5'h00;
    localparam logic [4:0]  SGMC_SHIFT_RESET = 5'h00;
    // attenuation path gain selects, amplification path selects
    localparam logic [1:0]  SGMC_G_0096     = 2'h0;
    localparam logic [1:0]  SGMC_G_0192     = 2'h1;
    localparam logic [1:0]  SGMC_G_0384     = 2'h2;
    localparam logic [1:0]  SGMC_G_0768     = 2'h3;
    localparam logic [1:0]  SGMC_G_1        = 2'h2;
    localparam logic [1:0]  SGMC_G_2        = 2'h3;
    // decoded analog path mode
    typedef enum logic [2:0] {
        SGMC_MODE_ATTEN,
        SGMC_MODE_AMP,
        SGMC_MODE_NULL,
        SGMC_MODE_HIZ,
        SGMC_MODE_UNDEF
    } sgmc_mode_t;
endpackage : sgmc_pkg

// File: logic/sgmc_top.sv
// serial configuration port: 5-bit shift register, holding register, mode decode
`timescale 1ns/1ns
`default_nettype none
module sgmc_top
    import sgmc_pkg::*;
(
    // system
    input  wire logic        CLK,
    input  wire logic        RESET,
    // serial pins
    input  wire logic        SCK,
    input  wire logic        CS_N,
    input  wire logic        SDI,
    output logic             SDO,
    // holding register and decoded controls
    output logic [4:0]       CFG_WORD,
    output logic [1:0]       GAIN_SEL,
    output logic             AMP_PAIR_ENABLE,
    output logic             OFFSET_NULL_MODE,
    output logic             OUTPUT_TRISTATE,
    output logic             SEL_ATTEN_PAIR,
    output logic             SEL_AMP_PAIR,
    output logic             INPUTS_CONNECTED,
    output logic             MODE_UNDEFINED,
    output sgmc_mode_t       MODE
);

    function automatic sgmc_mode_t sgmc_decode(input logic [4:0] w);
        sgmc_mode_t m;
        m = SGMC_MODE_ATTEN;
        if (w[SGMC_TRISTATE]) begin
            m = SGMC_MODE_HIZ;
        end else if (w[SGMC_NULL]) begin
            m = SGMC_MODE_NULL;
        end else if (w[SGMC_AMP_EN]) begin
            // only gain codes 10 and 11 are defined in amplification
            if (w[SGMC_GAIN_HI:SGMC_GAIN_LO] == SGMC_G_1 ||
                w[SGMC_GAIN_HI:SGMC_GAIN_LO] == SGMC_G_2) begin
                m = SGMC_MODE_AMP;
            end else begin
                m = SGMC_MODE_UNDEF;
            end
        end
        return m;
    endfunction : sgmc_decode

    // pin synchronisers; first stage feeds only the second
    logic [1:0] sck_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] sdi_sync_q;
    logic       sck_prev_q;
    logic       cs_prev_q;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sck_sync_q <= 2'h3;
            cs_sync_q  <= 2'h3;
            sdi_sync_q <= 2'h0;
            sck_prev_q <= 1'b1;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_sync_q <= {sck_sync_q[0], SCK};
            cs_sync_q  <= {cs_sync_q[0], CS_N};
            sdi_sync_q <= {sdi_sync_q[0], SDI};
            sck_prev_q <= sck_sync_q[1];
            cs_prev_q  <= cs_sync_q[1];
        end
    end

    logic sck_s;
    logic cs_s;
    logic sck_rise;
    logic cs_fall;
    logic cs_rise;
    assign sck_s    = sck_sync_q[1];
    assign cs_s     = cs_sync_q[1];
    assign sck_rise = sck_s && !sck_prev_q;
    assign cs_fall  = !cs_s && cs_prev_q;
    assign cs_rise  = cs_s && !cs_prev_q;
    sync_sdi_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> sdi_sync_q[1] == $past(sdi_sync_q[0]))
        else $error("data input synchroniser skipped a stage");
    sync_sck_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> sck_prev_q == $past(sck_s))
        else $error("serial clock edge detector lost a sample");
    sync_cs_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> cs_prev_q == $past(cs_s))
        else $error("chip select edge detector lost a sample");

    // frame armed only when chip select fell with the serial clock high;
    // a fall with clock low is meant for a shared converter and is ignored
    logic armed_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            armed_q <= 1'b0;
        end else if (cs_fall) begin
            armed_q <= sck_prev_q;
        end else if (cs_rise) begin
            armed_q <= 1'b0;
        end
    end
    arm_set_a: assert property (@(posedge CLK) disable iff (RESET)
        (cs_fall && sck_prev_q) |=> armed_q)
        else $error("chip select fall with clock high did not arm");
    arm_hold_a: assert property (@(posedge CLK) disable iff (RESET)
        (!cs_fall && !cs_rise) |=> armed_q == $past(armed_q))
        else $error("frame arming changed without a chip select edge");
    arm_clear_a: assert property (@(posedge CLK) disable iff (RESET)
        cs_rise |=> !armed_q)
        else $error("frame still armed after chip select rise");

    logic shift_en;
    assign shift_en = armed_q && !cs_s && sck_rise;
    one_bit_a: assert property (@(posedge CLK) disable iff (RESET)
        shift_en |=> !shift_en)
        else $error("one serial clock edge shifted twice");

    logic [4:0] shift_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            shift_q <= SGMC_SHIFT_RESET;
        end else if (shift_en) begin
            shift_q <= {shift_q[3:0], sdi_sync_q[1]};
        end
    end
    no_shift_idle_a: assert property (@(posedge CLK) disable iff (RESET)
        !armed_q |=> $stable(shift_q))
        else $error("shift register moved in an unarmed frame");
    no_shift_high_a: assert property (@(posedge CLK) disable iff (RESET)
        cs_s |=> $stable(shift_q))
        else $error("shift register moved with chip select high");

    // the pin copies the newly shifted top bit, so a chained part downstream
    // samples it on the next rising edge and two parts fill in ten clocks
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SDO <= 1'b0;
        end else if (shift_en) begin
            SDO <= shift_q[SGMC_WORD_BITS-2];
        end
    end
    sdo_hold_a: assert property (@(posedge CLK) disable iff (RESET)
        !shift_en |=> $stable(SDO))
        else $error("data output changed without a framed clock edge");
    sdo_track_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |-> SDO == shift_q[SGMC_WORD_BITS-1])
        else $error("data output does not follow the shift register top");
    reset_sdo_a: assert property (@(posedge CLK)
        RESET |=> !SDO && shift_q == SGMC_SHIFT_RESET && !armed_q)
        else $error("serial side not cleared by reset");

    logic [4:0] cfg_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cfg_q <= SGMC_CFG_RESET;
        end else if (cs_rise && armed_q) begin
            cfg_q <= shift_q;
        end
    end
    reset_cfg_a: assert property (@(posedge CLK)
        RESET |=> cfg_q == SGMC_CFG_RESET && CFG_WORD == SGMC_CFG_RESET)
        else $error("holding register not cleared by reset");
    unarmed_load_a: assert property (@(posedge CLK) disable iff (RESET)
        (cs_rise && !armed_q) |=> $stable(cfg_q))
        else $error("unarmed frame loaded the holding register");
    shift_cfg_a: assert property (@(posedge CLK) disable iff (RESET)
        shift_en |=> $stable(cfg_q))
        else $error("shifting changed the configuration");
    load_frame_a: assert property (@(posedge CLK) disable iff (RESET)
        (cs_rise && armed_q) |=> cfg_q == $past(shift_q))
        else $error("holding register did not take the shifted word");

    sgmc_mode_t mode_d;
    assign mode_d = sgmc_decode(cfg_q);

    // decoded outputs registered so they change one cycle after the load
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CFG_WORD         <= SGMC_CFG_RESET;
            GAIN_SEL         <= SGMC_G_0096;
            AMP_PAIR_ENABLE  <= 1'b0;
            OFFSET_NULL_MODE <= 1'b0;
            OUTPUT_TRISTATE  <= 1'b0;
            SEL_ATTEN_PAIR   <= 1'b1;
            SEL_AMP_PAIR     <= 1'b0;
            INPUTS_CONNECTED <= 1'b1;
            MODE_UNDEFINED   <= 1'b0;
            MODE             <= SGMC_MODE_ATTEN;
        end else begin
            CFG_WORD         <= cfg_q;
            GAIN_SEL         <= cfg_q[SGMC_GAIN_HI:SGMC_GAIN_LO];
            AMP_PAIR_ENABLE  <= cfg_q[SGMC_AMP_EN];
            OFFSET_NULL_MODE <= (mode_d == SGMC_MODE_NULL);
            OUTPUT_TRISTATE  <= cfg_q[SGMC_TRISTATE];
            SEL_ATTEN_PAIR   <= !cfg_q[SGMC_AMP_EN];
            SEL_AMP_PAIR     <= cfg_q[SGMC_AMP_EN];
            INPUTS_CONNECTED <= (mode_d == SGMC_MODE_ATTEN) || (mode_d == SGMC_MODE_AMP);
            MODE_UNDEFINED   <= (mode_d == SGMC_MODE_UNDEF);
            MODE             <= mode_d;
        end
    end
    cfg_word_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> CFG_WORD == $past(cfg_q))
        else $error("configuration word output lags wrongly");
    gain_sel_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> GAIN_SEL == $past(cfg_q[SGMC_GAIN_HI:SGMC_GAIN_LO]))
        else $error("gain select does not follow the gain bits");
    gain_code_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |-> GAIN_SEL == CFG_WORD[SGMC_GAIN_HI:SGMC_GAIN_LO])
        else $error("gain select disagrees with the word");
    atten_gain_a: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == SGMC_MODE_ATTEN) |-> !AMP_PAIR_ENABLE && SEL_ATTEN_PAIR &&
            INPUTS_CONNECTED && !OUTPUT_TRISTATE)
        else $error("attenuation mode controls inconsistent");
    amp_gain_a: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == SGMC_MODE_AMP) |-> GAIN_SEL[1] && SEL_AMP_PAIR)
        else $error("amplification mode with an undefined gain code");
    undef_flag_a: assert property (@(posedge CLK) disable iff (RESET)
        MODE_UNDEFINED |-> AMP_PAIR_ENABLE && !OUTPUT_TRISTATE && !OFFSET_NULL_MODE && !GAIN_SEL[1])
        else $error("undefined flag raised for a defined word");
    undef_mode_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |-> MODE_UNDEFINED == (MODE == SGMC_MODE_UNDEF))
        else $error("undefined flag disagrees with the mode");
    amp_pair_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> AMP_PAIR_ENABLE == $past(cfg_q[SGMC_AMP_EN]))
        else $error("amplification enable does not follow its bit");
    amp_route_a: assert property (@(posedge CLK) disable iff (RESET)
        AMP_PAIR_ENABLE |-> SEL_AMP_PAIR && !SEL_ATTEN_PAIR)
        else $error("amplification pair not routed");
    pair_excl_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |-> SEL_ATTEN_PAIR != SEL_AMP_PAIR)
        else $error("both or neither input pair selected");
    null_gain_a: assert property (@(posedge CLK) disable iff (RESET)
        OFFSET_NULL_MODE |-> MODE == SGMC_MODE_NULL && !OUTPUT_TRISTATE && !INPUTS_CONNECTED)
        else $error("null mode with inputs still connected");
    null_pri_a: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == SGMC_MODE_NULL) |-> OFFSET_NULL_MODE)
        else $error("null mode without the null output");
    hiz_out_a: assert property (@(posedge CLK) disable iff (RESET)
        OUTPUT_TRISTATE |-> MODE == SGMC_MODE_HIZ && !INPUTS_CONNECTED && !MODE_UNDEFINED)
        else $error("tristate output did not override the other bits");
    hiz_mode_a: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == SGMC_MODE_HIZ) |-> OUTPUT_TRISTATE && !OFFSET_NULL_MODE)
        else $error("tristate mode without the tristate output");
    tri_bit_a: assert property (@(posedge CLK) disable iff (RESET)
        1'b1 |=> OUTPUT_TRISTATE == $past(cfg_q[SGMC_TRISTATE]))
        else $error("tristate output does not follow its bit");
    connected_a: assert property (@(posedge CLK) disable iff (RESET)
        INPUTS_CONNECTED |-> MODE == SGMC_MODE_ATTEN || MODE == SGMC_MODE_AMP)
        else $error("inputs connected outside a gain mode");
    reset_mode_a: assert property (@(posedge CLK)
        RESET |=> MODE == SGMC_MODE_ATTEN && SEL_ATTEN_PAIR && !SEL_AMP_PAIR &&
            INPUTS_CONNECTED && !OUTPUT_TRISTATE && !MODE_UNDEFINED)
        else $error("decoded outputs not at reset values");

    // checks
    shift_only_a: assert property (@(posedge CLK) disable iff (RESET)
        !shift_en |=> shift_q == $past(shift_q))
        else $error("shift register moved without a framed clock edge");
    shift_in_a: assert property (@(posedge CLK) disable iff (RESET)
        shift_en |=> shift_q == {$past(shift_q[3:0]), $past(sdi_sync_q[1])})
        else $error("shift did not take the data input bit");
    sdo_top_a: assert property (@(posedge CLK) disable iff (RESET)
        shift_en |=> SDO == shift_q[SGMC_WORD_BITS-1])
        else $error("data output is not the top bit");
    arm_edge_a: assert property (@(posedge CLK) disable iff (RESET)
        (cs_fall && !sck_prev_q) |=> !armed_q)
        else $error("armed by chip select fall with clock low");
    cfg_hold_a: assert property (@(posedge CLK) disable iff (RESET)
        !(cs_rise && armed_q) |=> cfg_q == $past(cfg_q))
        else $error("holding register changed outside chip select rise");
    cfg_load_a: assert property (@(posedge CLK) disable iff (RESET)
        (cs_rise && armed_q) |=> ##1 CFG_WORD == $past(shift_q, 2))
        else $error("holding register not loaded from shift register");
    hiz_wins_a: assert property (@(posedge CLK) disable iff (RESET)
        cfg_q[SGMC_TRISTATE] |=> MODE == SGMC_MODE_HIZ && !OFFSET_NULL_MODE)
        else $error("tristate bit did not override");
    null_mode_a: assert property (@(posedge CLK) disable iff (RESET)
        (cfg_q[SGMC_NULL] && !cfg_q[SGMC_TRISTATE]) |=> OFFSET_NULL_MODE && !INPUTS_CONNECTED)
        else $error("null mode not entered");
    pair_sel_a: assert property (@(posedge CLK) disable iff (RESET)
        ##1 SEL_AMP_PAIR == $past(cfg_q[SGMC_AMP_EN]) && SEL_ATTEN_PAIR != SEL_AMP_PAIR)
        else $error("input pair select wrong");
    frame_c: cover property (@(posedge CLK) disable iff (RESET) cs_rise && armed_q);
    amp_c:   cover property (@(posedge CLK) disable iff (RESET) MODE == SGMC_MODE_AMP);
    hiz_c:   cover property (@(posedge CLK) disable iff (RESET) MODE == SGMC_MODE_HIZ);
    skip_c:  cover property (@(posedge CLK) disable iff (RESET) cs_fall && !sck_prev_q);

endmodule : sgmc_top
`default_nettype wire

// File: tb/sgmc_host.sv
// host-side serial master model driving the configuration pins
`timescale 1ns/1ns
`default_nettype none
module sgmc_host (
    // system
    input  wire logic CLK,
    // serial pins
    output var logic  SCK,
    output var logic  CS_N,
    output var logic  SDI
);
    initial begin
        SCK = 1'b1;
        CS_N = 1'b1;
        SDI = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
    endtask : wait_clk

    // n bits msb first; arm low drops the clock before the select edge
    task automatic send(input logic [9:0] data, input int n, input logic arm);
        SCK <= arm;
        wait_clk(4);
        CS_N <= 1'b0;
        wait_clk(4);
        for (int i = n - 1; i >= 0; i--) begin
            SCK <= 1'b0;
            SDI <= data[i];
            wait_clk(4);
            SCK <= 1'b1;
            wait_clk(4);
        end
        wait_clk(4);
        CS_N <= 1'b1;
        // released data line must not keep looking valid
        SDI <= ~data[0];
        SCK <= 1'b1;
        wait_clk(8);
    endtask : send
endmodule : sgmc_host
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ns
`default_nettype none
module tb
    import sgmc_pkg::*;
;
    logic clk, reset, sck, cs_n, sdi, sdo;
    logic [4:0] cfg;
    logic [1:0] gain;
    logic amp, nul, tri_s, s_att, s_amp, conn, undef;
    sgmc_mode_t mode;
    logic [9:0] sdo_log;
    int bad_count, tests_run, cycles;
    logic [4:0] words [10] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h14,
                               5'h1C, 5'h1F, 5'h1E, 5'h04, 5'h0C};

    sgmc_top dut_u (.CLK(clk), .RESET(reset), .SCK(sck), .CS_N(cs_n),
        .SDI(sdi), .SDO(sdo), .CFG_WORD(cfg), .GAIN_SEL(gain),
        .AMP_PAIR_ENABLE(amp), .OFFSET_NULL_MODE(nul), .OUTPUT_TRISTATE(tri_s),
        .SEL_ATTEN_PAIR(s_att), .SEL_AMP_PAIR(s_amp), .INPUTS_CONNECTED(conn),
        .MODE_UNDEFINED(undef), .MODE(mode));
    sgmc_host host_u (.CLK(clk), .SCK(sck), .CS_N(cs_n), .SDI(sdi));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [16:0] obs();
        return {cfg, gain, amp, nul, tri_s, s_att, s_amp, conn, undef, mode};
    endfunction : obs

    function automatic logic [16:0] exp_of(input logic [4:0] w);
        sgmc_mode_t m;
        m = w[0] ? SGMC_MODE_HIZ : w[1] ? SGMC_MODE_NULL : !w[2] ? SGMC_MODE_ATTEN
            : w[4] ? SGMC_MODE_AMP : SGMC_MODE_UNDEF;
        return {w, w[4:3], w[2], w[1] & !w[0], w[0], !w[2], w[2],
            m == SGMC_MODE_ATTEN || m == SGMC_MODE_AMP, m == SGMC_MODE_UNDEF, m};
    endfunction : exp_of

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // serial output seen just before each framed clock rise
    always @(posedge sck) if (!cs_n) sdo_log = {sdo_log[8:0], sdo};

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        reset = 1'b1;
        sdo_log = '0;
        host_u.wait_clk(3);
        reset <= 1'b0;
        host_u.wait_clk(1);
        check(obs(), exp_of(5'h00));
        check({16'h0000, sdo}, 17'h00000);
        foreach (words[i]) begin
            host_u.send({5'h00, words[i]}, 5, 1'b1);
            check(obs(), exp_of(words[i]));
        end
        host_u.send({5'h00, 5'h18}, 5, 1'b0);
        check(obs(), exp_of(5'h0C));
        sdo_log = '0;
        fork
            host_u.send({5'h13, 5'h09}, 10, 1'b1);
            begin
                host_u.wait_clk(60);
                check(obs(), exp_of(5'h0C));
            end
        join
        check(obs(), exp_of(5'h09));
        check({7'h00, sdo_log}, {7'h00, 5'h0C, 5'h13});
        reset <= 1'b1;
        host_u.wait_clk(3);
        reset <= 1'b0;
        host_u.wait_clk(2);
        check(obs(), exp_of(5'h00));
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
